/* File: include/lmf_pkg.sv */
// constants, field layouts and carriers of the line lut and metadata formatter
// assumes: compiled before hdl/lmf_formatter.sv; nothing is imported
`default_nettype none
package lmf_pkg;
  // register port map, byte offsets
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_LUT_INDEX = 8'h04;
  localparam logic [7:0] REG_LUT_DATA  = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0C;

  // control word: bit 0 metadata, bit 1 lut, bits 3:2 input width, 6:4 format
  localparam int         CTRL_META_BIT = 0;
  localparam int         CTRL_LUT_BIT  = 1;
  localparam int         CTRL_INW_LSB  = 2;
  localparam int         CTRL_FMT_LSB  = 4;
  localparam int         CTRL_W        = 7;
  localparam logic [6:0] CTRL_RESET    = 7'h00;
  localparam logic [11:0] LUT_INDEX_RESET = 12'h000;
  localparam logic [15:0] LUT_DATA_RESET  = 16'h0000;

  // component widths
  localparam logic [4:0] BITS_8   = 5'd8;
  localparam logic [4:0] BITS_10  = 5'd10;
  localparam logic [4:0] BITS_12  = 5'd12;
  localparam logic [4:0] BITS_16  = 5'd16;
  localparam int         IN_MAX_BITS = 12;

  // metadata record: 64 bytes sent as eight little-endian 64-bit words
  localparam int         REC_BYTES  = 64;
  localparam int         RESV_BYTES = 25;
  localparam int         META_WORDS = REC_BYTES / 8;
  localparam logic [2:0] META_LAST  = 3'(META_WORDS - 1);

  typedef enum logic [1:0] {
    INW_8  = 2'b00,
    INW_10 = 2'b01,
    INW_12 = 2'b10
  } lmf_inw_t;

  typedef enum logic [2:0] {
    FMT_MONO8    = 3'b000,
    FMT_MONO16   = 3'b001,
    FMT_RGB888   = 3'b010,
    FMT_RGB8888  = 3'b011,
    FMT_RGB10    = 3'b100,
    FMT_RGB16    = 3'b101
  } lmf_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LINE = 2'b01,
    ST_META = 2'b10
  } lmf_state_t;

  typedef struct packed {
    lmf_fmt_t   fmt;
    lmf_inw_t   in_w;
    logic       lut_en;
    logic       meta_en;
  } lmf_ctrl_t;

  // line_info_record fields in transmission order, lowest first
  typedef struct packed {
    logic [7:0]  bidir;
    logic [7:0]  gpo;
    logic [7:0]  gpi;
    logic [31:0] frame;
    logic [63:0] ts;
    logic [63:0] trig;
    logic [63:0] line;
    logic [63:0] enc;
  } lmf_rec_t;

  // everything that crosses into the camera clock domain as a level
  typedef struct packed {
    logic       req;
    lmf_ctrl_t  ctrl;
    logic [7:0] bidir;
    logic [7:0] gpo;
    logic [7:0] gpi;
    logic       trig;
    logic       rev;
    logic       fwd;
  } lmf_sync_t;

  localparam int SYNC_W = $bits(lmf_sync_t);
endpackage
`default_nettype wire

/* File: hdl/lmf_formatter.sv */
// line lut and metadata formatter: pixel mapping and per-line info record
// assumes: cam_clk runs freely; camera leaves at least nine cam_clk cycles
// between the end of one line and the start of the next when metadata is on
//
// Function
// - with metadata enabled, append a record after every line's pixels
// - every appended record is exactly 64 bytes long
// - record values are captured when line-valid rises, never later
// - 64-bit encoder count, up on forward pulses, down on reverse pulses
// - 64-bit count of line-valid starts, reported in each record
// - 64-bit count of line triggers sent, reported in each record
// - free-running 64-bit timestamp, reported in each record
// - 32-bit frame count; record carries the line's frame number
// - input, output and bidir pin levels reported as one byte each
// - the last 25 record bytes are reserved filler
// - 8-bit input uses 8- or 10-out tables, or 16-out with low bits
// - 10-bit input maps to 8, 10 or 16 bits, low aligned
// - 12-bit input maps to 8, 10 or 16; mono 8 keeps MSBs
// - lut off: raw pixel in low bits of the output word, or its MSBs when wider than the format
`default_nettype none
module lmf_formatter #(
  parameter int LUT_AW = 12
) (
  // system clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // register port, mclk
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // camera link, cam_clk
  input  wire logic        cam_clk,
  input  wire logic        cam_fval,
  input  wire logic        cam_lval,
  input  wire logic        cam_dval,
  input  wire logic [35:0] cam_pix,
  // status pins, asynchronous
  input  wire logic        enc_fwd,
  input  wire logic        enc_rev,
  input  wire logic        trig_sent,
  input  wire logic [7:0]  gp_in,
  input  wire logic [7:0]  gp_out,
  input  wire logic [7:0]  bidir_in,
  // formatted line stream, cam_clk
  output logic             out_valid,
  output logic             out_meta,
  output logic      [63:0] out_data
);
  localparam int LUT_N = 2 ** LUT_AW;

  if (LUT_AW < lmf_pkg::IN_MAX_BITS) begin : g_bad_aw
    $error("LUT_AW must cover a 12-bit pixel index");
  end

  // ---------------- mclk side ----------------
  lmf_pkg::lmf_ctrl_t ctrl;
  lmf_pkg::lmf_ctrl_t next_ctrl;
  logic [11:0]        lut_idx;
  logic [11:0]        next_lut_idx;
  logic [11:0]        lut_widx;
  logic [11:0]        next_lut_widx;
  logic [15:0]        lut_val;
  logic [15:0]        next_lut_val;
  logic               lut_req;
  logic               next_lut_req;
  logic [31:0]        next_reg_rdata;
  logic [2:0]         ms1;
  logic [2:0]         ms2;
  logic [2:0]         ms3;
  logic [2:0]         mlvl;
  logic [2:0]         next_mlvl;
  logic               lut_busy;

  // camera-side signals read here
  logic               lut_seen;
  logic               lv_q;
  logic               fv_q;

  // mlvl: {ack toggle, line active, frame active}
  assign lut_busy = (lut_req != mlvl[2]);

  always_comb begin
    next_ctrl      = ctrl;
    next_lut_idx   = lut_idx;
    next_lut_widx  = lut_widx;
    next_lut_val   = lut_val;
    next_lut_req   = lut_req;
    next_reg_rdata = 32'h0000_0000;
    next_mlvl      = (~(ms2 ^ ms3) & ms3) | ((ms2 ^ ms3) & mlvl);
    if (reg_wr) begin
      case (reg_addr)
        lmf_pkg::REG_CTRL: begin
          next_ctrl = lmf_pkg::lmf_ctrl_t'(reg_wdata[lmf_pkg::CTRL_W-1:0]);
        end
        lmf_pkg::REG_LUT_INDEX: begin
          next_lut_idx = reg_wdata[11:0];
        end
        lmf_pkg::REG_LUT_DATA: begin
          // a write while the previous entry is in flight is dropped
          if (!lut_busy) begin
            next_lut_widx = lut_idx;
            next_lut_val  = reg_wdata[15:0];
            next_lut_req  = ~lut_req;
            next_lut_idx  = lut_idx + 12'h001;
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        lmf_pkg::REG_CTRL:      next_reg_rdata = {25'h000_0000, ctrl};
        lmf_pkg::REG_LUT_INDEX: next_reg_rdata = {20'h0_0000, lut_idx};
        lmf_pkg::REG_LUT_DATA:  next_reg_rdata = {16'h0000, lut_val};
        lmf_pkg::REG_STATUS:    next_reg_rdata = {29'h0000_0000,
                                                  mlvl[0], mlvl[1], lut_busy};
        default:                next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    ms1 <= {lut_seen, lv_q, fv_q};
    ms2 <= ms1;
    ms3 <= ms2;
    if (sys_rst) begin
      ctrl      <= lmf_pkg::lmf_ctrl_t'(lmf_pkg::CTRL_RESET);
      lut_idx   <= lmf_pkg::LUT_INDEX_RESET;
      lut_widx  <= lmf_pkg::LUT_INDEX_RESET;
      lut_val   <= lmf_pkg::LUT_DATA_RESET;
      lut_req   <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      mlvl      <= 3'h0;
    end else begin
      ctrl      <= next_ctrl;
      lut_idx   <= next_lut_idx;
      lut_widx  <= next_lut_widx;
      lut_val   <= next_lut_val;
      lut_req   <= next_lut_req;
      reg_rdata <= next_reg_rdata;
      mlvl      <= next_mlvl;
    end
  end

  lut_busy_a : assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && reg_addr == lmf_pkg::REG_LUT_DATA && !lut_busy
    |=> lut_busy && lut_val == $past(reg_wdata[15:0]))
    else $error("lut write not taken");

  // ---------------- cam_clk side ----------------
  logic                crst_s1;
  logic                crst;
  lmf_pkg::lmf_sync_t  sync_in;
  lmf_pkg::lmf_sync_t  ps1;
  lmf_pkg::lmf_sync_t  ps2;
  lmf_pkg::lmf_sync_t  ps3;
  lmf_pkg::lmf_sync_t  plvl;
  lmf_pkg::lmf_sync_t  next_plvl;
  lmf_pkg::lmf_sync_t  rise;
  logic [lmf_pkg::SYNC_W-1:0] agree;

  lmf_pkg::lmf_state_t state;
  lmf_pkg::lmf_state_t next_state;
  logic [63:0]         enc;
  logic [63:0]         next_enc;
  logic [63:0]         line_cnt;
  logic [63:0]         next_line;
  logic [63:0]         trig_cnt;
  logic [63:0]         next_trig;
  logic [63:0]         ts;
  logic [63:0]         next_ts;
  logic [31:0]         frame_cnt;
  logic [31:0]         next_frame;
  lmf_pkg::lmf_rec_t   snap;
  lmf_pkg::lmf_rec_t   next_snap;
  lmf_pkg::lmf_rec_t   emit;
  lmf_pkg::lmf_rec_t   next_emit;
  logic [2:0]          mcnt;
  logic [2:0]          next_mcnt;
  logic                next_seen;
  logic                next_out_valid;
  logic                next_out_meta;
  logic [63:0]         next_out_data;
  logic [63:0]         meta_word;
  logic [63:0]         pk;
  logic [15:0]         mc [3];
  logic [15:0]         lut_q [LUT_N];
  logic                lut_we;

  assign sync_in = {lut_req, ctrl, bidir_in, gp_out, gp_in,
                    trig_sent, enc_rev, enc_fwd};
  assign agree   = ~(ps2 ^ ps3);
  assign lut_we  = (plvl.req != lut_seen);

  function automatic logic [15:0] wmask(input logic [4:0] n);
    wmask = 16'((17'h0_0001 << n) - 17'h0_0001);
  endfunction

  function automatic logic [4:0] in_bits(input lmf_pkg::lmf_inw_t w);
    case (w)
      lmf_pkg::INW_8:  in_bits = lmf_pkg::BITS_8;
      lmf_pkg::INW_10: in_bits = lmf_pkg::BITS_10;
      default:         in_bits = lmf_pkg::BITS_12;
    endcase
  endfunction

  function automatic logic [4:0] out_bits(input lmf_pkg::lmf_fmt_t f);
    case (f)
      lmf_pkg::FMT_MONO8, lmf_pkg::FMT_RGB888, lmf_pkg::FMT_RGB8888:
        out_bits = lmf_pkg::BITS_8;
      lmf_pkg::FMT_RGB10: out_bits = lmf_pkg::BITS_10;
      default:            out_bits = lmf_pkg::BITS_16;
    endcase
  endfunction

  // one component through the table or straight through
  function automatic logic [15:0] map_comp(input logic [11:0] raw,
                                           input logic [15:0] lv,
                                           input lmf_pkg::lmf_ctrl_t c);
    logic [4:0]  iw;
    logic [4:0]  ow;
    logic [15:0] r;
    iw = in_bits(c.in_w);
    ow = out_bits(c.fmt);
    r  = {4'h0, raw} & wmask(iw);
    if (c.lut_en) begin
      // a 16-bit slot keeps only input-width result bits, low aligned
      map_comp = lv & wmask((ow == lmf_pkg::BITS_16) ? iw : ow);
    end else if (iw > ow) begin
      map_comp = r >> (iw - ow);
    end else begin
      map_comp = r;
    end
  endfunction

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      mc[c] = map_comp(cam_pix[12*c +: 12],
                       lut_q[LUT_AW'(cam_pix[12*c +: 12] &
                                     wmask(in_bits(plvl.ctrl.in_w)))],
                       plvl.ctrl);
    end
    case (plvl.ctrl.fmt)
      lmf_pkg::FMT_MONO8:   pk = {56'h0, mc[0][7:0]};
      lmf_pkg::FMT_MONO16:  pk = {48'h0, mc[0]};
      lmf_pkg::FMT_RGB888:  pk = {40'h0, mc[2][7:0], mc[1][7:0], mc[0][7:0]};
      lmf_pkg::FMT_RGB8888: pk = {32'h0, 8'h00, mc[2][7:0], mc[1][7:0],
                                  mc[0][7:0]};
      lmf_pkg::FMT_RGB10:   pk = {34'h0, mc[2][9:0], mc[1][9:0], mc[0][9:0]};
      lmf_pkg::FMT_RGB16:   pk = {16'h0000, mc[2], mc[1], mc[0]};
      default:              pk = 64'h0000_0000_0000_0000;
    endcase
    case (mcnt)
      3'd0:    meta_word = emit.enc;
      3'd1:    meta_word = emit.line;
      3'd2:    meta_word = emit.trig;
      3'd3:    meta_word = emit.ts;
      3'd4:    meta_word = {8'h00, emit.bidir, emit.gpo, emit.gpi,
                            emit.frame};
      default: meta_word = 64'h0000_0000_0000_0000;
    endcase
  end

  always_comb begin
    next_plvl      = lmf_pkg::lmf_sync_t'((agree & ps3) | (~agree & plvl));
    rise           = lmf_pkg::lmf_sync_t'(next_plvl & ~plvl);
    next_state     = state;
    next_enc       = enc;
    next_line      = line_cnt;
    next_trig      = trig_cnt;
    next_ts        = ts + 64'h0000_0000_0000_0001;
    next_frame     = frame_cnt;
    next_snap      = snap;
    next_emit      = emit;
    next_mcnt      = mcnt;
    next_seen      = plvl.req;
    next_out_valid = 1'b0;
    next_out_meta  = 1'b0;
    next_out_data  = out_data;
    if (rise.fwd && !rise.rev) begin
      next_enc = enc + 64'h0000_0000_0000_0001;
    end else if (rise.rev && !rise.fwd) begin
      next_enc = enc - 64'h0000_0000_0000_0001;
    end
    if (rise.trig) begin
      next_trig = trig_cnt + 64'h0000_0000_0000_0001;
    end
    if (cam_fval && !fv_q) begin
      next_frame = frame_cnt + 32'h0000_0001;
    end
    if (cam_lval && !lv_q) begin
      next_line = line_cnt + 64'h0000_0000_0000_0001;
      // taken at line start so later pin or counter motion cannot leak in
      next_snap = '{enc: next_enc, line: next_line, trig: next_trig,
                    ts: ts, frame: next_frame, gpi: plvl.gpi,
                    gpo: plvl.gpo, bidir: plvl.bidir};
    end
    case (state)
      lmf_pkg::ST_IDLE: begin
        if (cam_lval) begin
          next_state = lmf_pkg::ST_LINE;
        end
      end
      lmf_pkg::ST_LINE: begin
        if (!cam_lval) begin
          if (plvl.ctrl.meta_en) begin
            next_state = lmf_pkg::ST_META;
            next_emit  = snap;
            next_mcnt  = 3'd0;
          end else begin
            next_state = lmf_pkg::ST_IDLE;
          end
        end
      end
      lmf_pkg::ST_META: begin
        next_out_valid = 1'b1;
        next_out_meta  = 1'b1;
        next_out_data  = meta_word;
        next_mcnt      = mcnt + 3'd1;
        if (mcnt == lmf_pkg::META_LAST) begin
          next_state = cam_lval ? lmf_pkg::ST_LINE : lmf_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = lmf_pkg::ST_IDLE;
      end
    endcase
    // pixels arriving while a record is sent are lost; no buffer here
    if (state != lmf_pkg::ST_META && cam_lval && cam_dval) begin
      next_out_valid = 1'b1;
      next_out_data  = pk;
    end
  end

  always_ff @(posedge cam_clk) begin
    crst_s1 <= sys_rst;
    crst    <= crst_s1;
    ps1     <= sync_in;
    ps2     <= ps1;
    ps3     <= ps2;
    lv_q    <= cam_lval;
    fv_q    <= cam_fval;
    if (crst) begin
      plvl      <= '0;
      state     <= lmf_pkg::ST_IDLE;
      enc       <= 64'h0000_0000_0000_0000;
      line_cnt  <= 64'h0000_0000_0000_0000;
      trig_cnt  <= 64'h0000_0000_0000_0000;
      ts        <= 64'h0000_0000_0000_0000;
      frame_cnt <= 32'h0000_0000;
      snap      <= '0;
      emit      <= '0;
      mcnt      <= 3'd0;
      lut_seen  <= 1'b0;
      out_valid <= 1'b0;
      out_meta  <= 1'b0;
      out_data  <= 64'h0000_0000_0000_0000;
    end else begin
      plvl      <= next_plvl;
      state     <= next_state;
      enc       <= next_enc;
      line_cnt  <= next_line;
      trig_cnt  <= next_trig;
      ts        <= next_ts;
      frame_cnt <= next_frame;
      snap      <= next_snap;
      emit      <= next_emit;
      mcnt      <= next_mcnt;
      lut_seen  <= next_seen;
      out_valid <= next_out_valid;
      out_meta  <= next_out_meta;
      out_data  <= next_out_data;
    end
  end

  // flip-flop table; reset loads an identity map
  for (genvar i = 0; i < LUT_N; i++) begin : g_lut
    always_ff @(posedge cam_clk) begin
      if (crst) begin
        lut_q[i] <= 16'(i);
      end else if (lut_we && LUT_AW'(lut_widx) == LUT_AW'(i)) begin
        lut_q[i] <= lut_val;
      end
    end
  end

  sequence meta_body_s;
    out_meta [*8] ##1 !out_meta;
  endsequence

  sequence meta_fields_s;
    out_data == emit.enc ##1 out_data == emit.line ##1 out_data == emit.trig
    ##1 out_data == emit.ts
    ##1 out_data == {8'h00, emit.bidir, emit.gpo, emit.gpi, emit.frame}
    ##1 out_data == 64'h0 [*3];
  endsequence

  meta_len_a : assert property (@(posedge cam_clk) disable iff (crst)
    $rose(out_meta) |-> meta_body_s)
    else $error("record is not eight words long");

  meta_after_a : assert property (@(posedge cam_clk) disable iff (crst)
    state == lmf_pkg::ST_LINE && !cam_lval && plvl.ctrl.meta_en
    |-> ##2 out_valid && out_meta)
    else $error("record missing after line");

  meta_off_a : assert property (@(posedge cam_clk) disable iff (crst)
    state == lmf_pkg::ST_LINE && !cam_lval && !plvl.ctrl.meta_en
    |-> ##2 !out_meta)
    else $error("record sent while disabled");

  meta_order_a : assert property (@(posedge cam_clk) disable iff (crst)
    $rose(out_meta) |-> meta_fields_s)
    else $error("record fields out of place");

  snap_start_a : assert property (@(posedge cam_clk) disable iff (crst)
    cam_lval && !lv_q |=> snap.line == $past(line_cnt) + 64'h1
    && snap.ts == $past(ts) && snap.gpi == $past(plvl.gpi))
    else $error("snapshot not taken at line start");

  enc_count_a : assert property (@(posedge cam_clk) disable iff (crst)
    rise.fwd && !rise.rev |=> enc == $past(enc) + 64'h1)
    else $error("encoder did not step forward");

  trig_count_a : assert property (@(posedge cam_clk) disable iff (crst)
    rise.trig |=> trig_cnt == $past(trig_cnt) + 64'h1)
    else $error("trigger count did not step");

  ts_run_a : assert property (@(posedge cam_clk) disable iff (crst)
    !crst |=> ts == $past(ts) + 64'h1)
    else $error("timestamp stalled");

  frame_count_a : assert property (@(posedge cam_clk) disable iff (crst)
    cam_fval && !fv_q |=> frame_cnt == $past(frame_cnt) + 32'h1)
    else $error("frame count did not step");

  raw_pack_a : assert property (@(posedge cam_clk) disable iff (crst)
    state != lmf_pkg::ST_META && cam_lval && cam_dval && !plvl.ctrl.lut_en
    && plvl.ctrl.fmt == lmf_pkg::FMT_MONO16
    && plvl.ctrl.in_w == lmf_pkg::INW_12
    |=> out_valid && out_data == {52'h0, $past(cam_pix[11:0])})
    else $error("raw pixel not in low bits");

  msb_keep_a : assert property (@(posedge cam_clk) disable iff (crst)
    state != lmf_pkg::ST_META && cam_lval && cam_dval && !plvl.ctrl.lut_en
    && plvl.ctrl.fmt == lmf_pkg::FMT_MONO8
    && plvl.ctrl.in_w == lmf_pkg::INW_12
    |=> out_data == {56'h0, $past(cam_pix[11:4])})
    else $error("mono 8 lost the top bits");
endmodule // lmf_formatter
`default_nettype wire

/* File: verif/lmf_cam_model.sv */
// camera link source: one line per frame, pixel value constant in a line
// assumes: cam_clk runs freely; send_line leaves room for the record
`default_nettype none
module lmf_cam_model (
  // camera clock
  input  wire logic        cam_clk,
  // camera link
  output logic             cam_fval,
  output logic             cam_lval,
  output logic             cam_dval,
  output logic      [35:0] cam_pix
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        act = 1'b0;
  logic [35:0] pv  = 36'h0;
  logic [38:0] bus = 39'h0;
  assign {cam_fval, cam_lval, cam_dval, cam_pix} = bus;
  // idle bus toggles so a stale pixel never passes for a fresh one
  always @(posedge cam_clk) begin
    bus <= {{3{act}}, act ? pv : ~bus[35:0]};
  end
  task automatic send_line(input logic [35:0] p, input int n);
    @(posedge cam_clk);
    act <= 1'b1;
    pv  <= p;
    repeat (n) @(posedge cam_clk);
    act <= 1'b0;
    // gap well above the nine idle cycles a record needs
    repeat (14) @(posedge cam_clk);
  endtask
endmodule // lmf_cam_model
`default_nettype wire

/* File: verif/lmf_formatter_tb.sv */
// bench of the formatter: register port, pixel mapping, line records
// assumes: lmf_pkg and lmf_cam_model are compiled first
`default_nettype none
module lmf_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk      = 1'b0;
  logic        cam_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [2:0]  pins      = 3'h0;
  logic [7:0]  gp_in     = 8'h0;
  logic [7:0]  gp_out    = 8'h0;
  logic [7:0]  bidir_in  = 8'h0;
  logic [31:0] reg_rdata;
  logic        cam_fval;
  logic        cam_lval;
  logic        cam_dval;
  logic [35:0] cam_pix;
  logic        out_valid;
  logic        out_meta;
  logic [63:0] out_data;
  logic [63:0] pix_q[$];
  logic [63:0] meta_q[$];
  logic [31:0] rd_v;
  int          n_fail      = 0;
  int          check_count = 0;
  int          nl          = 0;

  always #25 mclk = ~mclk;
  always #7.5 cam_clk = ~cam_clk;

  lmf_formatter i_lmf_formatter (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cam_clk(cam_clk), .cam_fval(cam_fval),
    .cam_lval(cam_lval), .cam_dval(cam_dval), .cam_pix(cam_pix),
    .enc_fwd(pins[0]), .enc_rev(pins[1]), .trig_sent(pins[2]),
    .gp_in(gp_in), .gp_out(gp_out), .bidir_in(bidir_in),
    .out_valid(out_valid), .out_meta(out_meta), .out_data(out_data));
  lmf_cam_model i_lmf_cam_model (.cam_clk(cam_clk), .cam_fval(cam_fval),
    .cam_lval(cam_lval), .cam_dval(cam_dval), .cam_pix(cam_pix));

  always @(posedge cam_clk) begin
    if (out_valid === 1'b1 && out_meta === 1'b1) meta_q.push_back(out_data);
    else if (out_valid === 1'b1) pix_q.push_back(out_data);
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge mclk);
    pins <= m;
    repeat (3) @(posedge mclk);
    pins <= 3'h0;
    repeat (3) @(posedge mclk);
  endtask
  // ctrl: format, input width, lut on or off, metadata off; three-pixel line
  task automatic run_case(input logic [2:0] f, input logic [1:0] w,
                          input logic lut, input logic [35:0] p,
                          input logic [63:0] e);
    wr(lmf_pkg::REG_CTRL, {25'h0, f, w, lut, 1'b0});
    repeat (10) @(posedge cam_clk);
    pix_q.delete();
    meta_q.delete();
    i_lmf_cam_model.send_line(p, 3);
    nl++;
    chk(64'(meta_q.size()), 64'h0);
    chk(64'(pix_q.size()), 64'h3);
    while (pix_q.size() > 0) chk(pix_q.pop_front(), e);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin : main
    logic [63:0] ts0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(lmf_pkg::REG_CTRL, rd_v);
    chk(64'(rd_v), 64'h0);
    rd(8'h10, rd_v);
    chk(64'(rd_v), 64'h0);
    wr(lmf_pkg::REG_LUT_INDEX, 32'h5);
    wr(lmf_pkg::REG_LUT_DATA, 32'h77);
    rd_v = 32'h1;
    for (int k = 0; k < 40 && rd_v[0] !== 1'b0; k++) begin
      rd(lmf_pkg::REG_STATUS, rd_v);
    end
    chk(64'(rd_v[0]), 64'h0);
    chk(64'(rd_v[2:1]), 64'h0);
    run_case(3'h0, 2'h0, 1'b1, 36'h5, 64'h77);
    run_case(3'h2, 2'h0, 1'b1, 36'h0_0500_5005, 64'h77_7777);
    run_case(3'h1, 2'h2, 1'b1, 36'hABC, 64'hABC);
    run_case(3'h0, 2'h0, 1'b0, 36'hA5, 64'hA5);
    run_case(3'h1, 2'h0, 1'b0, 36'hA5, 64'hA5);
    run_case(3'h2, 2'h0, 1'b0, 36'h0_3302_2011, 64'h33_2211);
    run_case(3'h3, 2'h0, 1'b0, 36'h0_3302_2011, 64'h33_2211);
    run_case(3'h1, 2'h1, 1'b0, 36'h3FF, 64'h3FF);
    run_case(3'h4, 2'h1, 1'b0, 36'h2_AA15_53FF, 64'h2AA5_57FF);
    run_case(3'h0, 2'h2, 1'b0, 36'hABC, 64'hAB);
    run_case(3'h1, 2'h2, 1'b0, 36'hABC, 64'hABC);
    run_case(3'h5, 2'h2, 1'b0, 36'h4_5612_3ABC, 64'h456_0123_0ABC);
    gp_in    <= 8'h5A;
    gp_out   <= 8'hC3;
    bidir_in <= 8'h81;
    for (int k = 0; k < 3; k++) pulse(3'h1);
    pulse(3'h2);
    pulse(3'h4);
    pulse(3'h4);
    wr(lmf_pkg::REG_CTRL, 32'h1);
    repeat (10) @(posedge cam_clk);
    meta_q.delete();
    // pin change after the line starts must not reach the record
    fork
      i_lmf_cam_model.send_line(36'h12, 6);
      begin
        for (int k = 0; k < 40 && cam_lval !== 1'b1; k++) @(posedge cam_clk);
        repeat (2) @(posedge mclk);
        gp_in <= 8'h00;
      end
    join
    nl++;
    chk(64'(meta_q.size()), 64'h8);
    chk(meta_q[0], 64'h2);
    chk(meta_q[1], 64'(nl));
    chk(meta_q[2], 64'h2);
    chk(meta_q[4], {32'h0081_C35A, 32'(nl)});
    for (int k = 5; k < 8; k++) chk(meta_q[k], 64'h0);
    ts0 = meta_q[3];
    meta_q.delete();
    // a long line lets the status flags settle while it is still running
    fork
      i_lmf_cam_model.send_line(36'h12, 60);
      begin
        for (int k = 0; k < 40 && cam_lval !== 1'b1; k++) @(posedge cam_clk);
        repeat (8) @(posedge mclk);
        rd(lmf_pkg::REG_STATUS, rd_v);
        chk(64'(rd_v), 64'h6);
      end
    join
    nl++;
    chk(64'(meta_q.size()), 64'h8);
    chk(meta_q[1], 64'(nl));
    chk(64'(meta_q[3] > ts0), 64'h1);
    chk(meta_q[4], {32'h0081_C300, 32'(nl)});
    wrap_up();
  end

  initial begin : watchdog
    for (int k = 0; k < 50000; k++) @(posedge mclk);
    n_fail++;
    wrap_up();
  end
endmodule // lmf_formatter_tb
`default_nettype wire
